// ---- design/arsms_pkg.sv ----
// constants, register layout and state type for the reset, start-up and mode sequencer
// assumes a 100 MHz mclk and a same-clock serial front end that hands over command words
// Functional notes
// - pin held low past width resets device
// - reset command acts only after full frame
// - short frame discards the reset command
// - command reset happens immediately once latched
// - ready rising edge opens the serial port
// - modulators wait 256 plus 44 periods
// - two fast samples, then cubic-sinc path
// - default ratio: samples at 1324, 3372 periods
// - resets repeat the wait, no settling interval
// - every reset reverts to external clock
// - continuous mode: one result per ratio periods
// - chop alternates polarity, averages two conversions
// - filter reset on swap, three conversions
// - four-bit delay field: 2 to 65536 periods
// - chop period is delay plus three conversions
// - chop restarts on pin fall, ratio change
// - first chop result: two intervals plus 44
// - no dc test signal under chop
// - two-bit field picks three power modes
// - sleep disables channels, resume restores operation
// - serial traffic ignored before ready edge
// - ready output active low, falls per result
package arsms_pkg;

    // timing
    localparam int unsigned MCLK_MHZ = 100;
    localparam int unsigned RESET_LOW_NS = 2000;
    localparam int unsigned RESET_LOW_CYC = (RESET_LOW_NS * MCLK_MHZ + 999) / 1000;
    localparam int unsigned WAIT_BASE_MOD = 256;
    localparam int unsigned WAIT_EXTRA_MOD = 44;
    localparam int unsigned START_WAIT_MOD = WAIT_BASE_MOD + WAIT_EXTRA_MOD;
    localparam int unsigned GC_FIRST_EXTRA_MOD = 44;
    localparam int unsigned FAST_SAMPLES = 2;
    localparam int unsigned FRAME_WORDS = 4;
    localparam int unsigned OSR_MIN = 128;

    // counter, command and address widths
    localparam int unsigned CNT_W = 18;
    localparam int unsigned LOW_W = 16;
    localparam int unsigned CMD_W = 16;
    localparam int unsigned ADR_W = 8;

    // serial command codes (values arbitrary)
    localparam logic [CMD_W-1:0] CMD_RESET = 16'h0011;
    localparam logic [CMD_W-1:0] CMD_STANDBY = 16'h0022;
    localparam logic [CMD_W-1:0] CMD_RESUME_COMMAND = 16'h0033;

    // register offsets
    localparam logic [ADR_W-1:0] CTRL_ADR = 8'h00;
    localparam logic [ADR_W-1:0] STAT_ADR = 8'h04;

    // control register fields
    localparam int unsigned CTRL_CHOP_EN_BIT = 0;
    localparam int unsigned CTRL_DLY_LSB = 4;
    localparam int unsigned CTRL_PWR_LSB = 8;
    localparam int unsigned CTRL_OSR_LSB = 10;
    localparam int unsigned CTRL_CLK_INT_BIT = 16;
    localparam int unsigned CTRL_DC_TEST_BIT = 17;
    localparam logic [31:0] CTRL_MASK = 32'h0003_1FF1;
    localparam logic [31:0] CTRL_RST = 32'h0000_0E00;

    // power levels
    localparam logic [1:0] PWR_VLP = 2'h0;
    localparam logic [1:0] PWR_LP = 2'h1;
    localparam logic [1:0] PWR_HR = 2'h2;
    localparam logic [1:0] PWR_BAD = 2'h3;

    // status register bits
    localparam int unsigned STAT_READY_BIT = 0;
    localparam int unsigned STAT_RUN_BIT = 1;
    localparam int unsigned STAT_SLEEP_BIT = 2;
    localparam int unsigned STAT_FAST_BIT = 3;
    localparam int unsigned STAT_POL_BIT = 4;
    localparam int unsigned STAT_DC_BIT = 5;

    typedef enum logic [1:0] {ST_HOLD, ST_WAIT, ST_RUN, ST_SLEEP} arsms_state_e;

endpackage

// ---- design/arsms_top.sv ----
// reset handling, fast start-up and conversion mode sequencing for a two-channel converter
// assumes a same-clock serial front end giving word and frame-end pulses, and a wishbone master
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module arsms_top #(
    parameter int unsigned MOD_DIV = 2
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [arsms_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // sync-or-reset pin, active low, asynchronous
    input wire logic sync_reset_n,
    // serial command words from the front end
    input wire logic cmd_word_valid,
    input wire logic [arsms_pkg::CMD_W-1:0] cmd_word,
    input wire logic frame_end,
    input wire logic data_read,
    // sequencer outputs
    output logic sample_available_n,
    output logic spi_ready,
    output logic fast_path_sel,
    output logic filter_reset,
    output logic chop_polarity,
    output logic chans_enabled,
    output logic clk_sel_int,
    output logic [1:0] power_level,
    output logic dc_test_active
);

    localparam int unsigned DIV_W = (MOD_DIV > 1) ? $clog2(MOD_DIV) : 1;

    // elaboration check on the modulator divider
    if (MOD_DIV < 1 || MOD_DIV > 256) begin : g_bad_div
        $error("MOD_DIV out of range");
    end

    logic pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_lvl_reg, pin_lvl_next;
    logic [arsms_pkg::LOW_W-1:0] low_cnt_reg;
    logic [DIV_W-1:0] div_cnt_reg;
    logic [2:0] words_reg;
    logic [arsms_pkg::CMD_W-1:0] cmd_reg;
    arsms_pkg::arsms_state_e state_reg;
    logic [arsms_pkg::CNT_W-1:0] cnt_reg, oversampling_ratio, dly, period, target;
    logic [1:0] samp_reg;
    logic gc_first_reg, pend_reg, ack_reg, ready_reg, fast_reg, frst_reg, pol_reg, dc_reg, chans_reg;
    logic [31:0] ctrl_reg, ctrl_next, dat_reg;
    logic pin_fall, pin_rst, mod_tick, cmd_done, cmd_reset, dev_reset, chop_en;
    logic ctrl_wr, osr_chg, restart, run_end, result, bus_req;

    // pin synchroniser: a new level counts once the second and third stages agree
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            pin_s3_reg <= 1'b1;
            pin_lvl_reg <= 1'b1;
        end else begin
            pin_s1_reg <= sync_reset_n;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_lvl_reg <= pin_lvl_next;
        end
    end
    assign pin_lvl_next = (pin_s2_reg == pin_s3_reg) ? pin_s3_reg : pin_lvl_reg;
    assign pin_fall = pin_lvl_reg & ~pin_lvl_next;

    // low-time measure
    // saturating count so a long hold keeps the device in reset
    always_ff @(posedge mclk) begin
        if (rst || pin_lvl_reg) begin
            low_cnt_reg <= '0;
        end else if (low_cnt_reg != arsms_pkg::LOW_W'(arsms_pkg::RESET_LOW_CYC)) begin
            low_cnt_reg <= low_cnt_reg + 1'b1;
        end
    end
    assign pin_rst = ~pin_lvl_reg && low_cnt_reg == arsms_pkg::LOW_W'(arsms_pkg::RESET_LOW_CYC);

    // modulator clock tick, derived from mclk
    always_ff @(posedge mclk) begin
        if (rst || mod_tick) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end
    assign mod_tick = div_cnt_reg == DIV_W'(MOD_DIV - 1);

    // words are ignored until the ready edge has been given
    always_ff @(posedge mclk) begin
        if (rst || frame_end) begin
            words_reg <= '0;
        end else if (cmd_word_valid && ready_reg) begin
            if (words_reg == 3'h0) begin
                cmd_reg <= cmd_word;
            end
            if (words_reg != 3'(arsms_pkg::FRAME_WORDS)) begin
                words_reg <= words_reg + 1'b1;
            end
        end
    end

    // a frame that ends short carries no command
    assign cmd_done = frame_end && ready_reg && words_reg == 3'(arsms_pkg::FRAME_WORDS);
    // reset acts the cycle its frame completes
    assign cmd_reset = cmd_done && cmd_reg == arsms_pkg::CMD_RESET;
    assign dev_reset = pin_rst || cmd_reset;

    // conversion period arithmetic, all in modulator periods
    assign chop_en = ctrl_reg[arsms_pkg::CTRL_CHOP_EN_BIT];
    assign oversampling_ratio = arsms_pkg::CNT_W'(arsms_pkg::OSR_MIN) << ctrl_reg[arsms_pkg::CTRL_OSR_LSB +: 3];
    // delay is two to the field plus one
    assign dly = arsms_pkg::CNT_W'(1) << ({1'b0, ctrl_reg[arsms_pkg::CTRL_DLY_LSB +: 4]} + 5'h01);
    assign period = dly + (oversampling_ratio << 1) + oversampling_ratio;
    // first interval of a restart carries the extra periods and gives no result
    assign target = !chop_en ? oversampling_ratio :
        gc_first_reg ? period + arsms_pkg::CNT_W'(arsms_pkg::GC_FIRST_EXTRA_MOD) : period;

    // pin fall or ratio change restarts chop conversions; turning chop on counts too
    assign restart = (chop_en && pin_fall) ||
        (ctrl_wr && ctrl_next[arsms_pkg::CTRL_CHOP_EN_BIT] && (osr_chg || !chop_en));
    // a ratio cut below the running count ends the period at once instead of wrapping
    assign run_end = state_reg == arsms_pkg::ST_RUN && mod_tick && !restart &&
        cnt_reg >= target - 1'b1;
    // one result per ratio in continuous mode
    assign result = run_end && (!chop_en || !gc_first_reg);

    // main sequencer: reset hold, start-up wait, run and sleep
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= arsms_pkg::ST_HOLD;
            cnt_reg <= '0;
            gc_first_reg <= 1'b1;
        end else if (dev_reset) begin
            state_reg <= arsms_pkg::ST_HOLD;
            cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                arsms_pkg::ST_HOLD: begin
                    state_reg <= arsms_pkg::ST_WAIT;
                    cnt_reg <= '0;
                end
                arsms_pkg::ST_WAIT: begin
                    if (mod_tick) begin
                        if (cnt_reg == arsms_pkg::CNT_W'(arsms_pkg::START_WAIT_MOD - 1)) begin
                            state_reg <= arsms_pkg::ST_RUN;
                            cnt_reg <= '0;
                            gc_first_reg <= 1'b1;
                        end else begin
                            cnt_reg <= cnt_reg + 1'b1;
                        end
                    end
                end
                arsms_pkg::ST_RUN: begin
                    if (cmd_done && cmd_reg == arsms_pkg::CMD_STANDBY) begin
                        state_reg <= arsms_pkg::ST_SLEEP;
                    end else if (restart) begin
                        cnt_reg <= '0;
                        gc_first_reg <= 1'b1;
                    end else if (run_end) begin
                        cnt_reg <= '0;
                        gc_first_reg <= 1'b0;
                    end else if (mod_tick) begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end
                end
                arsms_pkg::ST_SLEEP: begin
                    if (cmd_done && cmd_reg == arsms_pkg::CMD_RESUME_COMMAND) begin
                        state_reg <= arsms_pkg::ST_WAIT;
                        cnt_reg <= '0;
                    end
                end
            endcase
        end
    end

    // count results to hand over from fast path to cubic-sinc
    always_ff @(posedge mclk) begin
        if (rst || dev_reset) begin
            samp_reg <= '0;
            fast_reg <= 1'b1;
        end else begin
            if (result && samp_reg != 2'(arsms_pkg::FAST_SAMPLES)) begin
                samp_reg <= samp_reg + 1'b1;
            end
            fast_reg <= (result ? samp_reg + 1'b1 : samp_reg) < 2'(arsms_pkg::FAST_SAMPLES);
        end
    end

    // filter reset accompanies every swap and restart
    always_ff @(posedge mclk) begin
        if (rst || dev_reset) begin
            pol_reg <= 1'b0;
            frst_reg <= 1'b0;
        end else begin
            frst_reg <= restart || (run_end && chop_en);
            if (restart || !chop_en) begin
                pol_reg <= 1'b0;
            end else if (run_end) begin
                pol_reg <= ~pol_reg;
            end
        end
    end

    // result drives the output low; a pending result forces a short high first
    always_ff @(posedge mclk) begin
        if (rst || dev_reset) begin
            ready_reg <= 1'b0;
            sample_available_n <= 1'b0;
            pend_reg <= 1'b0;
        end else if (state_reg == arsms_pkg::ST_HOLD) begin
            ready_reg <= 1'b1;
            sample_available_n <= 1'b1;
        end else if (result && !sample_available_n) begin
            sample_available_n <= 1'b1;
            pend_reg <= 1'b1;
        end else if (result || pend_reg) begin
            sample_available_n <= 1'b0;
            pend_reg <= 1'b0;
        end else if (data_read) begin
            sample_available_n <= 1'b1;
        end
    end

    // wishbone decode; one wait state, ack drops the cycle after
    assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign ctrl_wr = bus_req && wb_we_i && wb_adr_i == arsms_pkg::CTRL_ADR;
    assign osr_chg = ctrl_wr && ctrl_next[arsms_pkg::CTRL_OSR_LSB +: 3] !=
        ctrl_reg[arsms_pkg::CTRL_OSR_LSB +: 3];

    // byte-lane merge; an illegal power code keeps the old level
    always_comb begin
        ctrl_next = ctrl_reg;
        for (int b = 0; b < 4; b++) begin
            if (wb_sel_i[b]) begin
                ctrl_next[8*b +: 8] = wb_dat_i[8*b +: 8];
            end
        end
        ctrl_next = ctrl_next & arsms_pkg::CTRL_MASK;
        if (ctrl_next[arsms_pkg::CTRL_PWR_LSB +: 2] == arsms_pkg::PWR_BAD) begin
            ctrl_next[arsms_pkg::CTRL_PWR_LSB +: 2] = ctrl_reg[arsms_pkg::CTRL_PWR_LSB +: 2];
        end
    end

    // every reset returns the control word, clock select included, to defaults
    always_ff @(posedge mclk) begin
        if (rst || dev_reset) begin
            ctrl_reg <= arsms_pkg::CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_reg <= ctrl_next;
        end
    end

    // bus answer; unmapped reads return zero, unmapped writes are dropped
    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= bus_req;
            dat_reg <= '0;
            if (bus_req && wb_adr_i == arsms_pkg::CTRL_ADR) begin
                dat_reg <= ctrl_reg;
            end else if (bus_req && wb_adr_i == arsms_pkg::STAT_ADR) begin
                dat_reg[arsms_pkg::STAT_READY_BIT] <= ready_reg;
                dat_reg[arsms_pkg::STAT_RUN_BIT] <= state_reg == arsms_pkg::ST_RUN;
                dat_reg[arsms_pkg::STAT_SLEEP_BIT] <= state_reg == arsms_pkg::ST_SLEEP;
                dat_reg[arsms_pkg::STAT_FAST_BIT] <= fast_reg;
                dat_reg[arsms_pkg::STAT_POL_BIT] <= pol_reg;
                dat_reg[arsms_pkg::STAT_DC_BIT] <= dc_reg;
            end
        end
    end

    // dc test blocked while chop is on
    always_ff @(posedge mclk) begin
        if (rst) begin
            dc_reg <= 1'b0;
        end else begin
            dc_reg <= ctrl_reg[arsms_pkg::CTRL_DC_TEST_BIT] && !chop_en;
        end
    end

    // channel enable kept in a flop so the pin never shows decode glitches
    always_ff @(posedge mclk) begin
        if (rst) begin
            chans_reg <= 1'b0;
        end else begin
            chans_reg <= state_reg == arsms_pkg::ST_RUN;
        end
    end

    // outputs, all from flops
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign spi_ready = ready_reg;
    assign fast_path_sel = fast_reg;
    assign filter_reset = frst_reg;
    assign chop_polarity = pol_reg;
    assign chans_enabled = chans_reg;
    assign clk_sel_int = ctrl_reg[arsms_pkg::CTRL_CLK_INT_BIT];
    assign power_level = ctrl_reg[arsms_pkg::CTRL_PWR_LSB +: 2];
    assign dc_test_active = dc_reg;

    // helper: modulator ticks spent in the start-up wait
    logic [arsms_pkg::CNT_W-1:0] wait_ticks_reg;
    always_ff @(posedge mclk) begin
        if (rst || state_reg != arsms_pkg::ST_WAIT) begin
            wait_ticks_reg <= '0;
        end else if (mod_tick) begin
            wait_ticks_reg <= wait_ticks_reg + 1'b1;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence leave_hold_s;
        state_reg == arsms_pkg::ST_HOLD && !dev_reset;
    endsequence

    pin_reset_a: assert property (pin_rst |=> state_reg == arsms_pkg::ST_HOLD)
        else $error("pin reset not taken");
    pin_hold_a: assert property (pin_rst ##1 pin_rst |-> state_reg == arsms_pkg::ST_HOLD)
        else $error("reset released while pin low");
    cmd_reset_a: assert property (cmd_reset |=> state_reg == arsms_pkg::ST_HOLD && !ready_reg)
        else $error("reset command not acted on");
    short_frame_a: assert property (frame_end && words_reg < 3'(arsms_pkg::FRAME_WORDS) &&
        !pin_rst && state_reg != arsms_pkg::ST_HOLD |=> state_reg != arsms_pkg::ST_HOLD)
        else $error("short frame caused reset");
    ready_edge_a: assert property (leave_hold_s |=> $rose(sample_available_n) ##0 ready_reg)
        else $error("ready edge missing after reset");
    ignore_early_a: assert property (!ready_reg && cmd_word_valid && !frame_end
        |=> words_reg == $past(words_reg))
        else $error("word taken before ready");
    wait_len_a: assert property ($past(state_reg) == arsms_pkg::ST_WAIT &&
        state_reg == arsms_pkg::ST_RUN |-> wait_ticks_reg == arsms_pkg::CNT_W'(arsms_pkg::START_WAIT_MOD))
        else $error("start-up wait length wrong");
    fast_path_a: assert property (state_reg == arsms_pkg::ST_RUN
        |-> fast_path_sel == (samp_reg < 2'(arsms_pkg::FAST_SAMPLES)))
        else $error("fast path select wrong");
    result_fall_a: assert property (result && !dev_reset |-> ##[1:2] !sample_available_n)
        else $error("no falling edge for result");
    chop_swap_a: assert property (run_end && chop_en && !dev_reset
        |=> filter_reset && chop_polarity != $past(chop_polarity))
        else $error("swap without filter reset");
    dc_block_a: assert property (chop_en |=> !dc_test_active)
        else $error("dc test active under chop");
    power_legal_a: assert property (power_level != arsms_pkg::PWR_BAD)
        else $error("illegal power level");
    clock_revert_a: assert property (dev_reset |=> !clk_sel_int)
        else $error("clock select kept over reset");

endmodule

// ---- tb/arsms_host_model.sv ----
// host model: sends serial command frames, drives the sync-or-reset pin, reads each result
// assumes the sequencer's same-clock word and frame-end pulse interface on mclk
`timescale 1ns/1ps
module arsms_host_model (
    // clock
    input wire logic mclk,
    // from the device
    input wire logic sample_available_n,
    // to the device
    output logic cmd_word_valid,
    output logic [arsms_pkg::CMD_W-1:0] cmd_word,
    output logic frame_end,
    output logic data_read,
    output logic sync_reset_n
);
    logic prev_n;
    logic [2:0] rd_cnt;

    // idle levels at time zero; pin released high
    initial begin
        cmd_word_valid = 1'b0;
        cmd_word = 16'h0000;
        frame_end = 1'b0;
        data_read = 1'b0;
        sync_reset_n = 1'b1;
        prev_n = 1'b1;
        rd_cnt = 3'h0;
    end

    // command in word zero, frame closed after nwords
    task automatic send_frame(input logic [arsms_pkg::CMD_W-1:0] code, input int nwords);
        for (int i = 0; i < nwords; i++) begin
            @(posedge mclk);
            cmd_word_valid <= 1'b1;
            cmd_word <= (i == 0) ? code : 16'h0000;
            @(posedge mclk);
            cmd_word_valid <= 1'b0;
            // word line is not held between words, so a stale value never reads as valid
            cmd_word <= ~cmd_word;
        end
        @(posedge mclk);
        frame_end <= 1'b1;
        @(posedge mclk);
        frame_end <= 1'b0;
    endtask

    // pin held low for ncyc clocks
    task automatic pin_low(input int ncyc);
        @(posedge mclk);
        sync_reset_n <= 1'b0;
        repeat (ncyc) @(posedge mclk);
        sync_reset_n <= 1'b1;
    endtask

    // read out each result a few clocks after the falling edge
    always @(posedge mclk) begin
        prev_n <= sample_available_n;
        data_read <= (rd_cnt == 3'h1);
        if (prev_n === 1'b1 && sample_available_n === 1'b0) begin
            rd_cnt <= 3'h4;
        end else if (rd_cnt != 3'h0) begin
            rd_cnt <= rd_cnt - 3'h1;
        end
    end
endmodule

// ---- tb/tb_adc_reset_startup_mode_sequencer.sv ----
// bench for the reset, start-up and conversion mode sequencer
// assumes the host model in arsms_host_model.sv and modulator period of one mclk
`timescale 1ns/1ps
module tb_adc_reset_startup_mode_sequencer;
    logic mclk = 1'b0;
    logic clk_run = 1'b1;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, sync_reset_n, cmd_word_valid, frame_end, data_read;
    logic [15:0] cmd_word;
    logic sample_available_n, spi_ready, fast_path_sel, filter_reset, chop_polarity;
    logic chans_enabled, clk_sel_int, dc_test_active, pol;
    logic [1:0] power_level;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int fr_cnt = 0;
    int n, t0, f0;

    arsms_top #(.MOD_DIV(1)) dut_u (.mclk(mclk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .sync_reset_n(sync_reset_n), .cmd_word_valid(cmd_word_valid), .cmd_word(cmd_word),
        .frame_end(frame_end), .data_read(data_read), .sample_available_n(sample_available_n),
        .spi_ready(spi_ready), .fast_path_sel(fast_path_sel), .filter_reset(filter_reset),
        .chop_polarity(chop_polarity), .chans_enabled(chans_enabled),
        .clk_sel_int(clk_sel_int), .power_level(power_level), .dc_test_active(dc_test_active));
    arsms_host_model host_u (.mclk(mclk), .sample_available_n(sample_available_n),
        .cmd_word_valid(cmd_word_valid), .cmd_word(cmd_word), .frame_end(frame_end),
        .data_read(data_read), .sync_reset_n(sync_reset_n));

    // 100 MHz clock
    always #5 mclk = ~mclk & clk_run;

    // cycle count on the falling edge, so reads at the rising edge never race it
    always @(negedge mclk) begin
        cycles <= cycles + 1;
        fr_cnt <= fr_cnt + ((filter_reset === 1'b1) ? 1 : 0);
        if (cycles == 20000) begin
            err_count++;
            $display("ERROR timeout expected end seen %0d cycles", cycles);
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    // classic wishbone cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge mclk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 64);
        if (wb_ack_o !== 1'b1) begin
            err_count++;
            $display("ERROR wb_ack_o expected 1 seen %b", wb_ack_o);
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // clocks until the next high-to-low step of the ready output
    task automatic wait_fall(output int c);
        logic p;
        p = sample_available_n;
        c = 0;
        forever begin
            @(posedge mclk);
            c++;
            if (p === 1'b1 && sample_available_n === 1'b0) break;
            p = sample_available_n;
        end
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge mclk);
    endtask

    initial begin
        settle(16);
        rst <= 1'b0;
        t0 = cycles;
        settle(4);
        chk("spi_ready", 1, spi_ready);
        chk("sample_available_n", 1, sample_available_n);
        chk("clk_sel_int", 0, clk_sel_int);
        chk("power_level", 2, power_level);
        wb(1'b0, arsms_pkg::CTRL_ADR, 32'h0000_0000);
        chk("ctrl reset", 32'h0000_0E00, rd);
        wb(1'b0, arsms_pkg::STAT_ADR, 32'h0000_0000);
        chk("status", 32'h0000_0009, rd);
        wait_fall(n);
        chk("first fast result", 1, 32'((cycles - t0) inside {[1324:1332]}));
        chk("fast path", 1, fast_path_sel);
        wait_fall(n);
        wait_fall(n);
        chk("first settled result", 1, 32'((cycles - t0) inside {[3372:3380]}));
        chk("fast path off", 0, fast_path_sel);
        wait_fall(n);
        chk("period 1024", 1024, n);
        wb(1'b0, 8'h08, 32'h0000_0000);
        chk("unmapped read", 0, rd);
        for (int p = 0; p < 3; p++) begin
            wb(1'b1, arsms_pkg::CTRL_ADR, 32'h0001_0000 | (p << 8));
            settle(2);
            chk("power_level", p, power_level);
        end
        wb(1'b1, arsms_pkg::CTRL_ADR, 32'h0001_0300);
        wb(1'b0, arsms_pkg::CTRL_ADR, 32'h0000_0000);
        chk("power 3 ignored", 32'h0001_0200, rd);
        chk("clk_sel_int", 1, clk_sel_int);
        wait_fall(n);
        wait_fall(n);
        chk("period 128", 128, n);
        host_u.pin_low(50);
        settle(8);
        chk("short pulse no reset", 1, clk_sel_int);
        host_u.send_frame(arsms_pkg::CMD_RESET, 3);
        settle(8);
        chk("short frame ignored", 1, clk_sel_int);
        host_u.send_frame(arsms_pkg::CMD_RESET, 4);
        t0 = cycles;
        settle(8);
        chk("command reset clk", 0, clk_sel_int);
        wb(1'b0, arsms_pkg::CTRL_ADR, 32'h0000_0000);
        chk("ctrl after reset", 32'h0000_0E00, rd);
        wait_fall(n);
        chk("restart result", 1, 32'((cycles - t0) inside {[1322:1334]}));
        wb(1'b1, arsms_pkg::CTRL_ADR, 32'h0001_0000);
        fork
            host_u.pin_low(250);
            begin
                settle(240);
                chk("pin reset held", 0, spi_ready);
                host_u.send_frame(arsms_pkg::CMD_STANDBY, 4);
            end
        join
        // host waits until the ready output rises after the pin reset
        n = 0;
        while (sample_available_n !== 1'b1 && n < 64) begin
            @(posedge mclk);
            n++;
        end
        chk("ready rise", 1, sample_available_n);
        chk("pin reset clk", 0, clk_sel_int);
        wait_fall(n);
        chk("early words ignored", 1, chans_enabled);
        wb(1'b1, arsms_pkg::CTRL_ADR, 32'h0002_0201);
        t0 = cycles;
        wait_fall(n);
        chk("first chop result", 1, 32'((cycles - t0) inside {[814:824]}));
        chk("dc test under chop", 0, dc_test_active);
        pol = chop_polarity;
        f0 = fr_cnt;
        wait_fall(n);
        chk("chop period", 386, n);
        chk("polarity swap", 1, 32'(chop_polarity != pol));
        chk("filter resets", 1, fr_cnt - f0);
        t0 = cycles;
        host_u.pin_low(50);
        wait_fall(n);
        chk("pin restart", 1, 32'((cycles - t0) inside {[816:830]}));
        host_u.send_frame(arsms_pkg::CMD_STANDBY, 4);
        settle(8);
        chk("standby", 0, chans_enabled);
        // host stops the clock while the device sleeps
        clk_run = 1'b0;
        #403;
        clk_run = 1'b1;
        wb(1'b0, arsms_pkg::CTRL_ADR, 32'h0000_0000);
        chk("ctrl kept", 32'h0002_0201, rd);
        host_u.send_frame(arsms_pkg::CMD_RESUME_COMMAND, 4);
        settle(310);
        chk("resumed", 1, chans_enabled);
        wb(1'b1, arsms_pkg::CTRL_ADR, 32'h0002_0200);
        settle(4);
        chk("dc test no chop", 1, dc_test_active);
        conclude();
    end
endmodule
